// file: hw/umcie_pkg.sv
/*
  Shared constants for the serial mode configuration and interrupt
  enable block: register offsets, mode register field positions,
  operating mode codes and interrupt source positions.
  Assumes a 32-bit classic Wishbone register bus, byte addressed.
*/
package umcie_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE      = 8'h04;
  localparam logic [7:0] OFS_IRQ_SET   = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_CFG_STAT  = 8'h30;

  // Reset values
  localparam logic [31:0] MODE_RST     = 32'h0000_0000;
  localparam logic [31:0] MASK_RST     = 32'h0000_0000;

  // Mode register field positions (low bit of each field)
  localparam int F_OPMODE    = 0;   // 4 bits
  localparam int F_CLKSRC    = 4;   // 2 bits
  localparam int F_CHARLEN   = 6;   // 2 bits
  localparam int F_SYNC      = 8;   // Also SPI clock phase
  localparam int F_PARITY    = 9;   // 3 bits
  localparam int F_STOP      = 12;  // 2 bits
  localparam int F_LOOP      = 14;  // 2 bits
  localparam int F_ORDER     = 16;  // Also SPI clock idle level
  localparam int F_NINE      = 17;
  localparam int F_CLKPIN    = 18;
  localparam int F_OVER      = 19;
  localparam int F_NAKINH    = 20;
  localparam int F_SUCCNAK   = 21;
  localparam int F_VARSYNC   = 22;
  localparam int F_MAXITER   = 24;  // 3 bits
  localparam int F_RXFILT    = 28;
  localparam int F_BIPHASE   = 29;
  localparam int F_SYNCEDGE  = 30;
  localparam int F_ONEBIT    = 31;
  localparam logic [31:0] MODE_WMASK = 32'hF77F_FFFF;

  // Interrupt source positions
  localparam logic [31:0] IRQ_VALID  = 32'h0118_3FFF;

  // Operating mode codes
  localparam logic [3:0] OPM_NORMAL = 4'h0;
  localparam logic [3:0] OPM_RS485  = 4'h1;
  localparam logic [3:0] OPM_HSHAKE = 4'h2;
  localparam logic [3:0] OPM_ISO_T0 = 4'h4;
  localparam logic [3:0] OPM_ISO_T1 = 4'h6;
  localparam logic [3:0] OPM_IRDA   = 4'h8;
  localparam logic [3:0] OPM_SPI_M  = 4'hE;
  localparam logic [3:0] OPM_SPI_S  = 4'hF;

  // Channel routing, clock source codes
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_ECHO   = 2'h1;
  localparam logic [1:0] LOOP_LOCAL  = 2'h2;
  localparam logic [1:0] LOOP_REMOTE = 2'h3;
  localparam logic [1:0] CLK_PERIPH  = 2'h0;
  localparam logic [1:0] CLK_DIV     = 2'h1;
  localparam logic [1:0] CLK_EXT     = 2'h3;

  // Oversampling ratios and stop length in half bits
  localparam logic [4:0] OSR_16 = 5'h10;
  localparam logic [4:0] OSR_8  = 5'h08;
  localparam logic [2:0] STOP_ONE  = 3'h2;
  localparam logic [2:0] STOP_ONEH = 3'h3;
  localparam logic [2:0] STOP_TWO  = 3'h4;

  typedef enum logic [2:0] {
    UMCIE_PARITY_EVEN, UMCIE_PARITY_ODD, UMCIE_PARITY_SPACE,
    UMCIE_PARITY_MARK, UMCIE_PARITY_NONE, UMCIE_PARITY_MULTIDROP
  } umcie_parity_t;

endpackage

// file: hw/umcie_top.sv
/*
  Mode register decode, line routing, receive filter, NAK control and
  interrupt enable mask for a multi-protocol serial transceiver.
  Assumes a classic Wishbone master on mclk, a shifter/baud core that
  consumes the decoded controls, and a status flag vector from it.
*/
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module umcie_top
  import umcie_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Status flags from the core and interrupt request
  input  wire logic [31:0] status_flags,
  output logic             irq,
  // Line pins and core line ends
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  input  wire logic        tx_core_out,
  output logic             rx_core_in,
  output logic             tx_allow,
  output logic             rx_allow,
  input  wire logic        sample_tick,
  // Clock pin
  input  wire logic        serial_clk_gen,
  output logic             sclk_pin_o,
  output logic             sclk_pin_oe,
  // Receive character result and NAK control
  input  wire logic        rx_char_done,
  input  wire logic        rx_parity_bad,
  input  wire logic        iter_clear,
  output logic             nak_send,
  output logic             retry_or_underrun,
  // Transmit holding write
  input  wire logic        tx_holding_write,
  input  wire logic        tx_holding_sync,
  output logic             tx_sync_cmd,
  // Decoded configuration
  output logic             biphase_tx_en,
  output logic             biphase_rx_en,
  output logic [4:0]       oversample_ratio,
  output logic [3:0]       char_bits,
  output logic             msb_first,
  output logic             spi_clock_idle_level,
  output logic             spi_change_on_lead,
  output logic             sync_mode,
  output logic [2:0]       stop_half_bits,
  output umcie_parity_t    parity_type,
  output logic [1:0]       clock_source_select,
  output logic [3:0]       op_mode,
  output logic             spi_mode,
  output logic             cfg_unsupported
);

  // Byte-lane expansion of the Wishbone select
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] mode_r;
  logic [31:0] mask_r;
  logic        wb_req;
  logic        wr_take;
  logic [31:0] wr_bits;
  logic [2:0]  filt_r;
  logic        rx_line;
  logic        rx_filtered;
  logic [2:0]  iter_cnt_r;
  logic        nak_r;
  logic        iter_r;
  logic        sync_sel_r;
  logic        iso_t0;
  logic [1:0]  loop_sel;
  logic        stop_rsvd;

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Bus request, one wait state, write data gated by byte lanes
  assign wb_req  = wb_cyc_i & wb_stb_i;
  assign wr_take = wb_req & wb_we_i & ~ack_r;
  assign wr_bits = wb_dat_i & lane_mask(wb_sel_i);

  // Acknowledge one cycle after the request, then drop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req & ~ack_r;
    end
  end
  assign wb_ack_o = ack_r;

  // Read data captured with the acknowledge; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_req & ~wb_we_i & ~ack_r) begin
      case (wb_adr_i)
        OFS_MODE:     dat_r <= mode_r;
        OFS_IRQ_MASK: dat_r <= mask_r;
        OFS_CFG_STAT: dat_r <= {30'h0, cfg_unsupported, iter_r};
        default:      dat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = dat_r;

  // Mode register, byte-lane writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RST;
    end else if (wr_take && wb_adr_i == OFS_MODE) begin
      mode_r <= (mode_r & ~(lane_mask(wb_sel_i) & MODE_WMASK))
              | (wr_bits & MODE_WMASK);
    end
  end

  // Interrupt mask: set and clear registers touch only ones written
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= MASK_RST;
    end else if (wr_take && wb_adr_i == OFS_IRQ_SET) begin
      mask_r <= mask_r | (wr_bits & IRQ_VALID);
    end else if (wr_take && wb_adr_i == OFS_IRQ_CLR) begin
      mask_r <= mask_r & ~(wr_bits & IRQ_VALID);
    end
  end

  // Interrupt request from enabled flags
  assign irq = |(status_flags & mask_r & IRQ_VALID);

  // Field decode
  assign op_mode  = mode_r[F_OPMODE +: 4];
  assign spi_mode = (op_mode == OPM_SPI_M) | (op_mode == OPM_SPI_S);
  assign iso_t0   = (op_mode == OPM_ISO_T0);
  assign loop_sel = mode_r[F_LOOP +: 2];
  assign clock_source_select = mode_r[F_CLKSRC +: 2];

  // Biphase codec enables both directions together
  assign biphase_tx_en = mode_r[F_BIPHASE];
  assign biphase_rx_en = mode_r[F_BIPHASE];

  // Oversampling ratio
  assign oversample_ratio = mode_r[F_OVER] ? OSR_8 : OSR_16;

  // Character length: nine bits, else five plus field
  assign char_bits = mode_r[F_NINE] ? 4'h9 :
                     (4'h5 + {2'h0, mode_r[F_CHARLEN +: 2]});

  // Shared bits: bit order or clock idle, sync or phase
  assign msb_first = ~spi_mode & mode_r[F_ORDER];
  assign spi_clock_idle_level = spi_mode & mode_r[F_ORDER];
  assign spi_change_on_lead = spi_mode & ~mode_r[F_SYNC];
  assign sync_mode = ~spi_mode & mode_r[F_SYNC];

  // Stop length in half bits; 1.5 only when asynchronous
  always_comb begin
    stop_rsvd = 1'b0;
    case (mode_r[F_STOP +: 2])
      2'h0: stop_half_bits = STOP_ONE;
      2'h1: begin
        stop_half_bits = STOP_ONEH;
        stop_rsvd = sync_mode;
      end
      2'h2: stop_half_bits = STOP_TWO;
      default: begin
        stop_half_bits = STOP_ONE;
        stop_rsvd = 1'b1;
      end
    endcase
  end

  // Parity type decode
  always_comb begin
    case (mode_r[F_PARITY +: 3])
      3'h0:    parity_type = UMCIE_PARITY_EVEN;
      3'h1:    parity_type = UMCIE_PARITY_ODD;
      3'h2:    parity_type = UMCIE_PARITY_SPACE;
      3'h3:    parity_type = UMCIE_PARITY_MARK;
      3'h4,
      3'h5:    parity_type = UMCIE_PARITY_NONE;
      default: parity_type = UMCIE_PARITY_MULTIDROP;
    endcase
  end

  // Reserved codes in stop, clock source and operating mode
  always_comb begin
    case (op_mode)
      OPM_NORMAL, OPM_RS485, OPM_HSHAKE, OPM_ISO_T0, OPM_ISO_T1,
      OPM_IRDA, OPM_SPI_M, OPM_SPI_S: cfg_unsupported = stop_rsvd;
      default: cfg_unsupported = 1'b1;
    endcase
    if (clock_source_select == 2'h2) begin
      cfg_unsupported = 1'b1;
    end
  end

  // Clock pin driven only from an internal source
  assign sclk_pin_oe = mode_r[F_CLKPIN]
                     & (clock_source_select != CLK_EXT);
  assign sclk_pin_o  = sclk_pin_oe & serial_clk_gen;

  // Receive majority filter sampled at sixteenth-bit ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_r <= 3'h7;
    end else if (sample_tick) begin
      filt_r <= {filt_r[1:0], rxd_pin};
    end
  end
  assign rx_filtered = (filt_r[0] & filt_r[1]) | (filt_r[1] & filt_r[2])
                     | (filt_r[0] & filt_r[2]);
  assign rx_line = mode_r[F_RXFILT] ? rx_filtered : rxd_pin;

  // Channel routing between pins and core
  always_comb begin
    txd_pin    = tx_core_out;
    rx_core_in = rx_line;
    tx_allow   = 1'b1;
    rx_allow   = 1'b1;
    case (loop_sel)
      LOOP_ECHO: txd_pin = rxd_pin;
      LOOP_LOCAL: begin
        txd_pin    = 1'b1;
        rx_core_in = tx_core_out;
      end
      LOOP_REMOTE: begin
        txd_pin  = rxd_pin;
        tx_allow = 1'b0;
        rx_allow = 1'b0;
      end
      default: txd_pin = tx_core_out;
    endcase
  end

  // Successive parity error count and NAK pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iter_cnt_r <= 3'h0;
      nak_r      <= 1'b0;
    end else begin
      nak_r <= 1'b0;
      if (iso_t0 && rx_char_done && !rx_parity_bad) begin
        iter_cnt_r <= 3'h0;
      end else if (iso_t0 && rx_char_done) begin
        if (!mode_r[F_SUCCNAK]) begin
          nak_r <= ~mode_r[F_NAKINH];
        end else if (iter_cnt_r < mode_r[F_MAXITER +: 3]) begin
          iter_cnt_r <= iter_cnt_r + 3'h1;
          nak_r <= ~mode_r[F_NAKINH];
        end
      end
    end
  end
  assign nak_send = nak_r;

  // Iteration flag: setting wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iter_r <= 1'b0;
    end else if (iso_t0 && rx_char_done && rx_parity_bad
                 && mode_r[F_SUCCNAK]
                 && iter_cnt_r >= mode_r[F_MAXITER +: 3]) begin
      iter_r <= 1'b1;
    end else if (iter_clear) begin
      iter_r <= 1'b0;
    end
  end
  assign retry_or_underrun = iter_r;

  // Sync bit captured from each holding register write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_sel_r <= 1'b0;
    end else if (tx_holding_write) begin
      sync_sel_r <= tx_holding_sync;
    end
  end
  assign tx_sync_cmd = mode_r[F_VARSYNC] ? sync_sel_r : mode_r[F_SYNC];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_set_write;
    wr_take && wb_adr_i == OFS_IRQ_SET;
  endsequence
  sequence s_clr_write;
    wr_take && wb_adr_i == OFS_IRQ_CLR;
  endsequence

  a_ack_single: assert property (wb_req && !ack_r |=> ack_r ##1 !ack_r)
    else $error("ack not a single cycle");
  a_set_mask: assert property (s_set_write |=>
    mask_r == ($past(mask_r) | ($past(wr_bits) & IRQ_VALID)))
    else $error("enable write did not set mask");
  a_clr_mask: assert property (s_clr_write |=>
    mask_r == ($past(mask_r) & ~($past(wr_bits) & IRQ_VALID)))
    else $error("disable write did not clear mask");
  a_mask_bits: assert property ((mask_r & ~IRQ_VALID) == 32'h0)
    else $error("mask bit outside sources");
  a_irq_level: assert property (irq == |(status_flags & mask_r))
    else $error("irq does not follow masked flags");
  a_nak_inhibit: assert property (mode_r[F_NAKINH] |=> !nak_r)
    else $error("nak while inhibited");
  a_nak_now: assert property (iso_t0 && rx_char_done && rx_parity_bad
    && !mode_r[F_SUCCNAK] && !mode_r[F_NAKINH] |=> nak_r)
    else $error("missing immediate nak");
  a_iter_flag: assert property (iso_t0 && rx_char_done && rx_parity_bad
    && mode_r[F_SUCCNAK] && iter_cnt_r >= mode_r[F_MAXITER +: 3]
    |=> iter_r && !nak_r)
    else $error("iteration limit not flagged");
  a_remote_loop: assert property (loop_sel == LOOP_REMOTE
    |-> txd_pin == rxd_pin && !tx_allow && !rx_allow)
    else $error("remote loopback routing wrong");
  a_clk_drive: assert property (clock_source_select == CLK_EXT
    |-> !sclk_pin_oe)
    else $error("clock pin driven from external source");
  a_nak_cause: assert property (nak_r |->
    $past(iso_t0 && rx_char_done && rx_parity_bad))
    else $error("nak without a bad character");
  a_filter_off: assert property (!mode_r[F_RXFILT]
    && loop_sel != LOOP_LOCAL |-> rx_core_in == rxd_pin)
    else $error("receive path altered with filter off");
  a_codec_pair: assert property (biphase_tx_en == biphase_rx_en)
    else $error("codec directions disagree");

endmodule

`default_nettype wire

// file: tb/tb_usart_mode_config_and_irq_enable.sv
/*
  Self-checking bench: register access over classic Wishbone, mode
  decode, line routing, receive filter, NAK control and irq mask.
  Assumes the package, the design and the line peer compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("wrong value at %0t: got %h exp %h", \
  $time, g, e); end end

module tb_usart_mode_config_and_irq_enable;
  import umcie_pkg::*;
  logic          mclk = 1'h0;
  logic          rst_b = 1'h0;
  logic          wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]    wb_adr_i = 8'h00;
  logic [3:0]    wb_sel_i = 4'hF;
  logic [31:0]   wb_dat_i = 32'h0, status_flags = 32'h0, wb_dat_o, rd;
  logic          tx_core_out = 1'h0, sample_tick = 1'h0;
  logic          serial_clk_gen = 1'h1, iter_clear = 1'h0;
  logic          rx_char_done = 1'h0, rx_parity_bad = 1'h0;
  logic          tx_holding_write = 1'h0, tx_holding_sync = 1'h0;
  logic          wb_ack_o, irq, rxd_pin, txd_pin, rx_core_in;
  logic          tx_allow, rx_allow, sclk_pin_o, sclk_pin_oe, nak_send;
  logic          retry_or_underrun, tx_sync_cmd, biphase_tx_en;
  logic          biphase_rx_en, msb_first, spi_clock_idle_level;
  logic          spi_change_on_lead, sync_mode, spi_mode, cfg_unsupported;
  logic [4:0]    oversample_ratio;
  logic [3:0]    char_bits, op_mode;
  logic [2:0]    stop_half_bits;
  logic [1:0]    clock_source_select;
  umcie_parity_t parity_type;
  logic [3:0]    opc [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hE, 4'hF};
  int            failures = 0;
  int            samples_checked = 0;
  int            i;

  umcie_top u_dut (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .status_flags,
    .irq, .rxd_pin, .txd_pin, .tx_core_out, .rx_core_in, .tx_allow,
    .rx_allow, .sample_tick, .serial_clk_gen, .sclk_pin_o, .sclk_pin_oe,
    .rx_char_done, .rx_parity_bad, .iter_clear, .nak_send,
    .retry_or_underrun, .tx_holding_write, .tx_holding_sync, .tx_sync_cmd,
    .biphase_tx_en, .biphase_rx_en, .oversample_ratio, .char_bits,
    .msb_first, .spi_clock_idle_level, .spi_change_on_lead, .sync_mode,
    .stop_half_bits, .parity_type, .clock_source_select, .op_mode,
    .spi_mode, .cfg_unsupported);
  umcie_line_peer u_peer (.mclk(mclk), .rxd(rxd_pin), .txd(txd_pin));

  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;

  // Classic Wishbone cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 40) failures++;
    #1;
  endtask

  task automatic setm(input logic [31:0] d);
    wb(1'h1, OFS_MODE, d, 4'hF);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0, 4'hF);
    `CHK(rd, e)
  endtask

  // One received character, flagged bad or good
  task automatic chr(input logic bad);
    @(posedge mclk);
    rx_char_done  <= 1'h1;
    rx_parity_bad <= bad;
    @(posedge mclk);
    rx_char_done <= 1'h0;
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      sample_tick <= 1'h1;
      @(posedge mclk);
      sample_tick <= 1'h0;
    end
    #1;
  endtask

  task automatic hold_wr(input logic v);
    @(posedge mclk);
    tx_holding_write <= 1'h1;
    tx_holding_sync  <= v;
    @(posedge mclk);
    tx_holding_write <= 1'h0;
    #1;
  endtask

  task automatic flags(input logic [31:0] v);
    @(posedge mclk);
    status_flags <= v;
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    wrap_up;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (3) @(posedge mclk);
    rchk(OFS_MODE, MODE_RST);
    rchk(OFS_IRQ_MASK, MASK_RST);
    `CHK(oversample_ratio, OSR_16)
    wb(1'h1, OFS_IRQ_SET, 32'hFFFF_FFFF, 4'h1);
    rchk(OFS_IRQ_MASK, 32'h0000_00FF);
    wb(1'h1, OFS_IRQ_SET, 32'hFFFF_FFFF, 4'hF);
    rchk(OFS_IRQ_MASK, IRQ_VALID);
    wb(1'h1, OFS_IRQ_CLR, 32'h0000_0001, 4'hF);
    rchk(OFS_IRQ_MASK, IRQ_VALID & ~32'h1);
    rchk(OFS_IRQ_SET, 32'h0);
    wb(1'h1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    rchk(8'h40, 32'h0);
    flags(32'h0000_0001);
    `CHK(irq, 1'h0)
    flags(32'h0100_0000);
    `CHK(irq, 1'h1)
    flags(32'h0000_4000);
    `CHK(irq, 1'h0)
    setm(32'hFFFF_FFFF);
    rchk(OFS_MODE, MODE_WMASK);
    // Character length, parity, operating mode tables
    for (i = 0; i < 4; i++) begin
      setm(32'(i) << F_CHARLEN);
      `CHK(char_bits, 4'(5 + i))
    end
    setm(32'h1 << F_NINE);
    `CHK(char_bits, 4'h9)
    setm(32'h1 << F_OVER);
    `CHK(oversample_ratio, OSR_8)
    for (i = 0; i < 8; i++) begin
      setm(32'(i) << F_PARITY);
      `CHK(parity_type, umcie_parity_t'(i < 4 ? i : (i < 6 ? 4 : 5)))
    end
    for (i = 0; i < 8; i++) begin
      setm(32'(opc[i]));
      `CHK(op_mode, opc[i])
      `CHK(spi_mode, 1'(opc[i][3:1] == 3'h7))
      `CHK(cfg_unsupported, 1'h0)
    end
    setm(32'h3);
    `CHK(cfg_unsupported, 1'h1)
    // Clock source and clock pin drive
    for (i = 0; i < 4; i++) begin
      setm((32'(i) << F_CLKSRC) | (32'h1 << F_CLKPIN));
      `CHK(clock_source_select, 2'(i))
      `CHK(sclk_pin_oe, 1'(i != 3))
      `CHK(sclk_pin_o, 1'(i != 3))
      `CHK(cfg_unsupported, 1'(i == 2))
    end
    setm(32'h0);
    `CHK(sclk_pin_oe, 1'h0)
    for (i = 0; i < 3; i++) begin
      setm(32'(i) << F_STOP);
      `CHK(stop_half_bits, 3'(2 + i))
    end
    setm((32'h1 << F_STOP) | (32'h1 << F_SYNC));
    `CHK(cfg_unsupported, 1'h1)
    `CHK(sync_mode, 1'h1)
    setm(32'h1 << F_ORDER);
    `CHK(msb_first, 1'h1)
    setm(32'(OPM_SPI_M) | (32'h1 << F_ORDER));
    `CHK(spi_clock_idle_level, 1'h1)
    `CHK(spi_change_on_lead, 1'h1)
    setm(32'(OPM_SPI_S) | (32'h1 << F_SYNC));
    `CHK(spi_clock_idle_level, 1'h0)
    `CHK(spi_change_on_lead, 1'h0)
    setm(32'h1 << F_BIPHASE);
    `CHK(biphase_tx_en & biphase_rx_en, 1'h1)
    setm(32'h0);
    `CHK(biphase_tx_en | biphase_rx_en, 1'h0)
    // Line routing with line high and transmitter low
    for (i = 0; i < 4; i++) begin
      setm(32'(i) << F_LOOP);
      `CHK(txd_pin, 1'(i != 0))
      `CHK(u_peer.seen_r, 1'(i != 0))
      if (i < 3) `CHK(rx_core_in, 1'(i != 2))
      `CHK(tx_allow & rx_allow, 1'(i != 3))
    end
    // Majority filter: one low sample is not enough, then one high sample after three low is not enough
    setm(32'h1 << F_RXFILT);
    u_peer.put(1'h0);
    tick(1);
    `CHK(rx_core_in, 1'h1)
    tick(2);
    `CHK(rx_core_in, 1'h0)
    u_peer.put(1'h1);
    tick(1);
    `CHK(rx_core_in, 1'h0)
    // NAK on parity errors
    setm(32'(OPM_ISO_T0));
    chr(1'h1);
    `CHK(nak_send, 1'h1)
    chr(1'h0);
    `CHK(nak_send, 1'h0)
    setm(32'(OPM_ISO_T0) | (32'h1 << F_NAKINH));
    chr(1'h1);
    `CHK(nak_send, 1'h0)
    setm(32'(OPM_ISO_T0) | (32'h1 << F_SUCCNAK) | (32'h2 << F_MAXITER));
    chr(1'h0);
    for (i = 0; i < 3; i++) begin
      chr(1'h1);
      `CHK(nak_send, 1'(i < 2))
    end
    `CHK(retry_or_underrun, 1'h1)
    rchk(OFS_CFG_STAT, 32'h1);
    @(posedge mclk);
    iter_clear <= 1'h1;
    @(posedge mclk);
    iter_clear <= 1'h0;
    #1;
    `CHK(retry_or_underrun, 1'h0)
    // Sync type from holding writes or from the sync bit
    setm(32'h1 << F_VARSYNC);
    hold_wr(1'h1);
    `CHK(tx_sync_cmd, 1'h1)
    hold_wr(1'h0);
    `CHK(tx_sync_cmd, 1'h0)
    setm(32'h1 << F_SYNC);
    `CHK(tx_sync_cmd, 1'h1)
    // Second reset in mid-run clears the mask
    @(posedge mclk);
    rst_b <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (3) @(posedge mclk);
    rchk(OFS_IRQ_MASK, 32'h0);
    wrap_up;
  end
endmodule

`default_nettype wire

// file: tb/umcie_line_peer.sv
/*
  Serial peer on the line side: drives the receive pin level and
  watches the transmit pin.
  Assumes the bench calls put() to change the line level.
*/
`timescale 1ns/100ps
`default_nettype none

module umcie_line_peer (
  input  wire logic mclk,
  output logic      rxd,
  input  wire logic txd
);
  logic line_r = 1'h1;
  logic seen_r;

  // The line idles at mark until the bench asks for a level
  assign rxd = line_r;

  // Last transmit level seen, read back by the bench
  always_ff @(posedge mclk) begin
    seen_r <= txd;
  end

  // New level right after a clock edge
  task automatic put(input logic v);
    @(posedge mclk);
    line_r <= v;
  endtask
endmodule

`default_nettype wire
